// ==== rtl/fws_pkg.sv ====
`default_nettype none
package fws_pkg;

  // Data bus bit positions of the status bits
  localparam int unsigned TOGGLE_A_POS  = 6;
  localparam int unsigned TOGGLE_B_POS  = 2;
  localparam int unsigned TIMEOUT_POS   = 5;
  localparam int unsigned POLL_POS      = 7;
  localparam int unsigned WINDOW_POS    = 3;

  // Reset command data byte
  localparam logic [7:0]  RESET_CMD     = 8'hf0;
  localparam logic [7:0]  RESET_VAL_8   = 8'h00;

  // Bus cycle timing in clock cycles at 100 MHz
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned T_ACCESS_NS   = 70;
  localparam int unsigned T_GAP_NS      = 20;
  localparam int unsigned T_WPULSE_NS   = 40;
  localparam int unsigned ACCESS_CYC    =
    (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned GAP_CYC       =
    (T_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WPULSE_CYC    =
    (T_WPULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_W         = 4;

  // Poll outcome codes
  typedef enum logic [1:0] {
    FWS_RES_NONE,
    FWS_RES_DONE,
    FWS_RES_FAIL
  } fws_result_t;

endpackage
`default_nettype wire

// ==== rtl/fws_bus_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface fws_bus_if #(
  parameter int unsigned ADDR_W = 21
);
  logic              start;
  logic              write;
  logic [ADDR_W-1:0] addr;
  logic [7:0]        wdata;
  logic [7:0]        rdata;
  logic              done;
  logic              ce_n;
  logic              oe_n;
  logic              we_n;
  logic [ADDR_W-1:0] pin_addr;
  logic [7:0]        dq_out;
  logic              dq_oe_n;

  modport ctrl (
    output start, write, addr, wdata,
    input  rdata, done
  );
  modport cyc (
    input  start, write, addr, wdata,
    output rdata, done, ce_n, oe_n, we_n, pin_addr, dq_out, dq_oe_n
  );
endinterface
`default_nettype wire

// ==== rtl/fws_bus_cycle.sv ====
`timescale 1ns/10ps
`default_nettype none
module fws_bus_cycle #(
  parameter int unsigned ADDR_W = 21
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic resetn_i,
  // Data bus input from the device
  input  wire logic [7:0] dq_i,
  // Request side and pins
  fws_bus_if.cyc    bus
);
  typedef enum logic [1:0] {
    FWS_C_IDLE,
    FWS_C_STROBE,
    FWS_C_GAP
  } fws_cstate_t;

  typedef struct packed {
    fws_cstate_t                 st;
    logic [fws_pkg::CYC_W-1:0]   cnt;
    logic                        write;
    logic                        ce_n;
    logic                        oe_n;
    logic                        we_n;
    logic [ADDR_W-1:0]           addr;
    logic [7:0]                  dq_out;
    logic                        dq_oe_n;
    logic [7:0]                  rdata;
    logic                        done;
  } fws_cyc_t;

  fws_cyc_t s_reg;
  fws_cyc_t s_next;

  always_comb begin
    s_next      = s_reg;
    s_next.done = 1'b0;
    case (s_reg.st)
      FWS_C_IDLE: begin
        if (bus.start) begin
          s_next.st      = FWS_C_STROBE;
          s_next.write   = bus.write;
          s_next.addr    = bus.addr;
          s_next.dq_out  = bus.wdata;
          s_next.ce_n    = 1'b0;
          s_next.oe_n    = bus.write;
          s_next.we_n    = ~bus.write;
          s_next.dq_oe_n = ~bus.write;
          s_next.cnt     = bus.write ?
            fws_pkg::CYC_W'(fws_pkg::WPULSE_CYC) :
            fws_pkg::CYC_W'(fws_pkg::ACCESS_CYC);
        end
      end
      FWS_C_STROBE: begin
        if (s_reg.cnt > fws_pkg::CYC_W'(1)) begin
          s_next.cnt = s_reg.cnt - fws_pkg::CYC_W'(1);
        end else begin
          // Both strobes rise together, so each read ends one cycle
          s_next.st    = FWS_C_GAP;
          s_next.ce_n  = 1'b1;
          s_next.oe_n  = 1'b1;
          s_next.we_n  = 1'b1;
          s_next.rdata = dq_i;
          s_next.cnt   = fws_pkg::CYC_W'(fws_pkg::GAP_CYC);
        end
      end
      FWS_C_GAP: begin
        s_next.dq_oe_n = 1'b1;
        if (s_reg.cnt > fws_pkg::CYC_W'(1)) begin
          s_next.cnt = s_reg.cnt - fws_pkg::CYC_W'(1);
        end else begin
          s_next.st   = FWS_C_IDLE;
          s_next.done = 1'b1;
        end
      end
      default: s_next.st = FWS_C_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_reg         <= '0;
      s_reg.st      <= FWS_C_IDLE;
      s_reg.ce_n    <= 1'b1;
      s_reg.oe_n    <= 1'b1;
      s_reg.we_n    <= 1'b1;
      s_reg.dq_oe_n <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign bus.ce_n     = s_reg.ce_n;
  assign bus.oe_n     = s_reg.oe_n;
  assign bus.we_n     = s_reg.we_n;
  assign bus.pin_addr = s_reg.addr;
  assign bus.dq_out   = s_reg.dq_out;
  assign bus.dq_oe_n  = s_reg.dq_oe_n;
  assign bus.rdata    = s_reg.rdata;
  assign bus.done     = s_reg.done;
endmodule
`default_nettype wire

// ==== rtl/fws_poll_ctrl.sv ====
// Behaviour
// R1 - Busy line is shared open-drain, pulled up
// R2 - Busy line valid after final write strobe
// R3 - Busy line low while program or erase
// R4 - Busy line high when ready or suspended
// R5 - Toggle bit A flips each read while busy
// R6 - Toggle bit A readable anywhere, valid early
// R7 - Read cycles delimited by output or chip-select
// R8 - All-protected erase toggles about 100 us
// R9 - Partly protected erase skips protected sectors
// R10 - Toggle A stops once erase suspended
// R11 - Protected program toggles about 2 us
// R12 - Suspend-program toggles until program finishes
// R13 - Toggle bit B flips inside erasing sectors
// R14 - Host reads status twice and compares
// R15 - Steady toggle means operation complete
// R16 - Toggling with timeout set: recheck, else reset
// R17 - Resumed polling restarts from first step
// R18 - Timeout bit high on pulse limit overrun
// R19 - Programming one over zero ends in timeout
// R20 - Host resets device after any timeout; the code resets only if toggle A still differs on the recheck read
// R21 - Poll bit complements data while programming
// R22 - Erase window bit rises after time-out
// R23 - Reset command is one write of f0
// R24 - Toggle advances once per completed read
`timescale 1ns/10ps
`default_nettype none
module fws_poll_ctrl #(
  parameter int unsigned ADDR_W = 21
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              resetn_i,
  // User orders
  input  wire logic              poll_start_i,
  input  wire logic              abort_i,
  input  wire logic [ADDR_W-1:0] poll_addr_i,
  output logic                   busy_o,
  output logic                   done_o,
  output logic                   fail_o,
  output logic [7:0]             array_data_o,
  // Device pins
  output logic                   ce_n_o,
  output logic                   oe_n_o,
  output logic                   we_n_o,
  output logic [ADDR_W-1:0]      addr_o,
  input  wire logic [7:0]        dq_i,
  output logic [7:0]             dq_o,
  output logic                   dq_oe_n_o,
  input  wire logic              ready_busy_n_out_i,
  output logic                   ready_busy_n_seen_o
);
  // Refused at elaboration so a bad width never reaches the pins
  if (ADDR_W < 1 || ADDR_W > 32) begin : g_addr_w_check
    $error("ADDR_W out of range");
  end

  typedef enum logic [2:0] {
    FWS_P_IDLE,
    FWS_P_READ1,
    FWS_P_READ2,
    FWS_P_RECHK,
    FWS_P_RESET,
    FWS_P_DATA
  } fws_pstate_t;

  typedef struct packed {
    fws_pstate_t          st;
    logic                 issued;
    logic                 first_tog;
    logic                 busy;
    logic                 done;
    logic                 fail;
    logic [7:0]           data;
    logic                 rb_seen;
  } fws_poll_t;

  fws_poll_t s_reg;
  fws_poll_t s_next;

  fws_bus_if #(.ADDR_W(ADDR_W)) bus ();

  fws_bus_cycle #(.ADDR_W(ADDR_W)) fws_bus_cycle_i (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .dq_i     (dq_i),
    .bus      (bus)
  );

  function automatic logic tog_a(input logic [7:0] d);
    tog_a = d[fws_pkg::TOGGLE_A_POS];
  endfunction

  logic cyc_free;
  assign cyc_free = ~s_reg.issued | bus.done;

  always_comb begin
    s_next       = s_reg;
    s_next.done  = 1'b0;
    bus.start    = 1'b0;
    bus.write    = 1'b0;
    bus.addr     = poll_addr_i;
    bus.wdata    = fws_pkg::RESET_VAL_8;
    // Shared pin sampled once per clock; wired-AND is outside this end
    s_next.rb_seen = ready_busy_n_out_i; // see R1
    if (bus.done) begin
      s_next.issued = 1'b0;
    end
    case (s_reg.st)
      FWS_P_IDLE: begin
        // Every new request starts from the first read
        if (poll_start_i) begin // see R17
          s_next.st   = FWS_P_READ1;
          s_next.busy = 1'b1;
          s_next.fail = 1'b0;
        end
      end
      FWS_P_READ1: begin
        if (abort_i && cyc_free) begin // see R17
          s_next.st   = FWS_P_IDLE;
          s_next.busy = 1'b0;
        end else if (!s_reg.issued) begin
          bus.start     = 1'b1;
          s_next.issued = 1'b1;
        end else if (bus.done) begin
          s_next.first_tog = tog_a(bus.rdata);
          s_next.st        = FWS_P_READ2;
        end
      end
      FWS_P_READ2, FWS_P_RECHK: begin
        if (!s_reg.issued) begin
          bus.start     = 1'b1;
          s_next.issued = 1'b1;
        end else if (bus.done) begin
          // Each full read ends a device cycle, so compare back to back
          if (tog_a(bus.rdata) == s_reg.first_tog) begin // see R14, R24
            s_next.st = FWS_P_DATA; // see R15
          end else if (s_reg.st == FWS_P_RECHK) begin
            s_next.st = FWS_P_RESET; // see R16
          end else if (bus.rdata[fws_pkg::TIMEOUT_POS]) begin // see R18
            s_next.first_tog = tog_a(bus.rdata);
            s_next.st        = FWS_P_RECHK; // see R16
          end else if (abort_i) begin
            s_next.st   = FWS_P_IDLE; // see R17
            s_next.busy = 1'b0;
          end else begin
            s_next.first_tog = tog_a(bus.rdata);
          end
        end
      end
      FWS_P_RESET: begin
        if (!s_reg.issued) begin
          bus.start     = 1'b1;
          bus.write     = 1'b1;
          bus.wdata     = fws_pkg::RESET_CMD; // see R23
          s_next.issued = 1'b1;
        end else if (bus.done) begin
          s_next.st   = FWS_P_IDLE; // see R20
          s_next.busy = 1'b0;
          s_next.done = 1'b1;
          s_next.fail = 1'b1;
        end
      end
      FWS_P_DATA: begin
        // Array data is valid only on the read after toggling stops
        if (!s_reg.issued) begin
          bus.start     = 1'b1;
          s_next.issued = 1'b1;
        end else if (bus.done) begin
          s_next.data = bus.rdata; // see R15
          s_next.st   = FWS_P_IDLE;
          s_next.busy = 1'b0;
          s_next.done = 1'b1;
        end
      end
      default: s_next.st = FWS_P_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_reg         <= '0;
      s_reg.st      <= FWS_P_IDLE;
      s_reg.rb_seen <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign busy_o              = s_reg.busy;
  assign done_o              = s_reg.done;
  assign fail_o              = s_reg.fail;
  assign array_data_o        = s_reg.data;
  assign ready_busy_n_seen_o = s_reg.rb_seen;
  assign ce_n_o              = bus.ce_n;
  assign oe_n_o              = bus.oe_n;
  assign we_n_o              = bus.we_n;
  assign addr_o              = bus.pin_addr;
  assign dq_o                = bus.dq_out;
  assign dq_oe_n_o           = bus.dq_oe_n;

  property p_fail_on_reset;
    @(posedge clk_i) disable iff (!resetn_i)
    $rose(fail_o) |-> $past(s_reg.st) == FWS_P_RESET;
  endproperty
  a_fail_on_reset: assert property (p_fail_on_reset) // see R20
    else $error("fail raised without reset write");

  property p_reset_data;
    @(posedge clk_i) disable iff (!resetn_i)
    (!we_n_o && !dq_oe_n_o) |-> dq_o == fws_pkg::RESET_CMD;
  endproperty
  a_reset_data: assert property (p_reset_data) // see R23
    else $error("write data is not the reset command");

  property p_strobes_exclusive;
    @(posedge clk_i) disable iff (!resetn_i)
    !(!oe_n_o && !we_n_o);
  endproperty
  a_strobes_exclusive: assert property (p_strobes_exclusive) // see R7
    else $error("output and write strobes both low");

  property p_start_reads;
    @(posedge clk_i) disable iff (!resetn_i)
    (s_reg.st == FWS_P_IDLE && poll_start_i) |-> ##2 (!oe_n_o && !ce_n_o);
  endproperty
  a_start_reads: assert property (p_start_reads) // see R14
    else $error("poll did not begin with a read");

  property p_done_pulse;
    @(posedge clk_i) disable iff (!resetn_i)
    done_o |=> !done_o;
  endproperty
  a_done_pulse: assert property (p_done_pulse) // see R15
    else $error("done longer than one cycle");

  property p_done_ends_busy;
    @(posedge clk_i) disable iff (!resetn_i)
    $rose(done_o) |-> !busy_o && $past(busy_o);
  endproperty
  a_done_ends_busy: assert property (p_done_ends_busy) // see R16
    else $error("done without busy falling");

  property p_rb_follow;
    @(posedge clk_i) disable iff (!resetn_i)
    ##1 ready_busy_n_seen_o == $past(ready_busy_n_out_i);
  endproperty
  a_rb_follow: assert property (p_rb_follow) // see R1
    else $error("ready busy sample lags");

  property p_read_release;
    @(posedge clk_i) disable iff (!resetn_i)
    $fell(oe_n_o) |-> (!oe_n_o)[*7] ##1 oe_n_o;
  endproperty
  a_read_release: assert property (p_read_release) // see R24
    else $error("read strobe length wrong");
endmodule
`default_nettype wire

// ==== testbench/fws_dev_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module fws_dev_model #(
  parameter int unsigned ADDR_W = 21
) (
  // Strobes and address
  input  wire logic              ce_n_i,
  input  wire logic              oe_n_i,
  input  wire logic              we_n_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  // Data bus and busy line
  input  wire logic [7:0]        dq_i,
  input  wire logic              dq_oe_n_i,
  output logic [7:0]             dq_o,
  output logic                   rb_line_o
);
  logic       busy_reg  = 1'b0;
  logic       susp_reg  = 1'b0;
  logic       stuck_reg = 1'b0;
  logic       tog_a_reg = 1'b0;
  logic       tog_b_reg = 1'b0;
  logic [4:0] sect_reg  = 5'h00;
  logic [7:0] mem_reg   = 8'h00;
  logic [7:0] last_reg  = 8'h00;
  int         len_reg   = 0;
  int         tmo_at    = 0;
  int         k_reg     = 0;
  int         n_reads   = 0;
  int         n_resets  = 0;
  logic [7:0] shown;
  wire logic  rd_act  = !ce_n_i && !oe_n_i && we_n_i;
  wire logic  in_sect = addr_i[ADDR_W-1 -: 5] == sect_reg;

  always_comb begin
    shown = mem_reg;
    if (busy_reg || susp_reg) begin
      shown    = 8'h00;
      shown[7] = susp_reg;
      shown[6] = tog_a_reg;
      shown[5] = busy_reg && (k_reg + 1 >= tmo_at);
      shown[3] = busy_reg && in_sect;
      shown[2] = in_sect && tog_b_reg;
    end
  end

  // A released bus shows the inverse of its last value, never a held one
  always_comb begin
    if (!dq_oe_n_i) dq_o = dq_i;
    else if (rd_act) dq_o = shown;
    else dq_o = ~last_reg;
  end

  // Open-drain line seen through its pull-up
  assign rb_line_o = !(busy_reg && !susp_reg);

  // A read ends when either strobe rises
  always @(negedge rd_act) begin
    last_reg = shown;
    n_reads++;
    if (busy_reg) begin
      tog_a_reg = ~tog_a_reg;
      k_reg++;
      if (!stuck_reg && k_reg >= len_reg) busy_reg = 1'b0;
    end
    if (busy_reg || susp_reg) tog_b_reg = ~tog_b_reg;
  end

  always @(posedge we_n_i) begin
    if (dq_i == 8'hf0) begin
      busy_reg = 1'b0;
      susp_reg = 1'b0;
      n_resets++;
    end
  end

  task automatic begin_op(input int len, input int tmo, input logic stuck,
                          input logic susp, input logic [7:0] data,
                          input logic [4:0] sect);
    mem_reg   = data;
    len_reg   = len;
    tmo_at    = tmo;
    stuck_reg = stuck;
    susp_reg  = susp;
    busy_reg  = !susp && (len > 0);
    k_reg     = 0;
    sect_reg  = sect;
    tog_b_reg = 1'b1;
    // Toggling stops on the value the array byte shows, as on silicon
    tog_a_reg = susp ? 1'b1 : data[6] ^ ~len[0];
  endtask
endmodule
`default_nettype wire

// ==== testbench/fws_poll_ctrl_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module fws_poll_ctrl_tb;
  localparam int unsigned ADDR_W = 21;
  logic              clk_i        = 1'b0;
  logic              resetn_i     = 1'b0;
  logic              poll_start_i = 1'b0;
  logic              abort_i      = 1'b0;
  logic [ADDR_W-1:0] poll_addr_i  = '0;
  logic              busy_o;
  logic              done_o;
  logic              fail_o;
  logic [7:0]        array_data_o;
  logic              ce_n;
  logic              oe_n;
  logic              we_n;
  logic [ADDR_W-1:0] addr;
  logic [7:0]        dq_ctrl;
  logic [7:0]        dq_bus;
  logic              dq_oe_n;
  logic              rb_line;
  logic              rb_seen;
  logic              saw_low;
  int                n_fail       = 0;
  int                total_checks = 0;
  int                seed         = 59947;

  always #5 clk_i = ~clk_i;

  fws_poll_ctrl #(.ADDR_W(ADDR_W)) fws_poll_ctrl_i (
    .clk_i(clk_i), .resetn_i(resetn_i), .poll_start_i(poll_start_i),
    .abort_i(abort_i), .poll_addr_i(poll_addr_i), .busy_o(busy_o),
    .done_o(done_o), .fail_o(fail_o), .array_data_o(array_data_o),
    .ce_n_o(ce_n), .oe_n_o(oe_n), .we_n_o(we_n), .addr_o(addr),
    .dq_i(dq_bus), .dq_o(dq_ctrl), .dq_oe_n_o(dq_oe_n),
    .ready_busy_n_out_i(rb_line), .ready_busy_n_seen_o(rb_seen));

  fws_dev_model #(.ADDR_W(ADDR_W)) fws_dev_model_i (
    .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .addr_i(addr),
    .dq_i(dq_ctrl), .dq_oe_n_i(dq_oe_n), .dq_o(dq_bus),
    .rb_line_o(rb_line));

  function automatic logic [7:0] susp_byte(input logic in_sect);
    return {2'b11, 3'b000, in_sect, 2'b00};
  endfunction

  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Polling has no upper bound on the device side, so the wait is capped
  task automatic run_poll(input logic [ADDR_W-1:0] a);
    int i;
    repeat (2) @(negedge clk_i);
    poll_addr_i  = a;
    poll_start_i = 1'b1;
    @(negedge clk_i);
    poll_start_i = 1'b0;
    saw_low      = 1'b0;
    for (i = 0; i < 4000; i++) begin
      @(negedge clk_i);
      if (rb_seen === 1'b0) saw_low = 1'b1;
      if (done_o === 1'b1) break;
    end
    if (i == 4000) begin
      n_fail++;
      complete_run();
    end
  endtask

  initial begin
    int t;
    int m;
    int n;
    int r0;
    int q0;
    logic [7:0] d;
    logic [4:0] s;
    logic [ADDR_W-1:0] a;
    repeat (3) @(negedge clk_i);
    resetn_i = 1'b1;
    // Modes: 0 finishes, 1 timeout bit as toggling stops, 2 stuck, 3 suspend
    for (t = 0; t < 12; t++) begin
      m = t % 4;
      n = (t == 0) ? 0 : 1 + int'($unsigned($random(seed)) % 8);
      if (m == 1) n = n + n % 2;
      d  = 8'($random(seed));
      s  = 5'($random(seed));
      a  = {s, 16'($random(seed))};
      r0 = fws_dev_model_i.n_resets;
      q0 = fws_dev_model_i.n_reads;
      fws_dev_model_i.begin_op(n, (m == 1 || m == 2) ? n : 1 << 20,
                               m == 2, m == 3, d, s);
      run_poll(a);
      r0 = fws_dev_model_i.n_resets - r0;
      q0 = fws_dev_model_i.n_reads - q0;
      d  = (m == 3) ? susp_byte(1'b1) : d;
      check("fail", 8'(fail_o), 8'(m == 2));
      check("resets", 8'(r0), 8'(m == 2));
      if (m != 2) check("data", array_data_o, d);
      if (n == 0) check("reads", 8'(q0), 8'h03);
      check("busy seen", 8'(saw_low), 8'(n > 0 && m != 3));
      check("ready after", 8'(rb_seen), 8'h01);
    end
    // Abort in mid-poll, then a fresh start must work from read one
    fws_dev_model_i.begin_op(1 << 20, 1 << 20, 1'b0, 1'b0, 8'h3c, 5'h00);
    repeat (2) @(negedge clk_i);
    poll_start_i = 1'b1;
    @(negedge clk_i);
    poll_start_i = 1'b0;
    repeat (80) @(negedge clk_i);
    abort_i = 1'b1;
    for (t = 0; t < 200 && busy_o !== 1'b0; t++) @(negedge clk_i);
    abort_i = 1'b0;
    check("abort idle", 8'(busy_o), 8'h00);
    fws_dev_model_i.begin_op(5, 1 << 20, 1'b0, 1'b0, 8'h3c, 5'h00);
    run_poll(a);
    check("restart data", array_data_o, 8'h3c);
    check("restart fail", 8'(fail_o), 8'h00);
    complete_run();
  end
endmodule
`default_nettype wire
